// >>> rtl/dspcd_core.sv
// Decode and execution of control-word access, indexed loads and position branch.
// Notes on behaviour
// - Control write replaces each field whose mask bit is 1 from the register.
// - Control write leaves fields with clear mask bit unchanged.
// - Control read copies selected fields into target register; other bits stay.
// - Indexed byte load from base plus index, zero-extended.
// - Indexed halfword load from base plus index, sign-extended.
// - Indexed word load from base plus index, written whole.
// - Position branch taken only when position field is 32 or more.
// - Reserved opcode slots raise a reserved-instruction exception, doing nothing.
// - Higher-level opcode slots raise a reserved-instruction exception.
// - Field-class slots decode further through the minor field.
// - Major opcode row is bits 31..29, column bits 28..26.
// - Position field marks left-most bit of extraction; branch examines it.
`timescale 1ns/1ps
module dspcd_core
    import dspcd_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic resetn,
    // Instruction issue.
    input wire dspcd_issue_s issue,
    output logic issueReady,
    // Data memory.
    output dspcd_mem_s memReq,
    input wire logic memRespValid,
    input wire logic [DATA_W-1:0] memRespData,
    // Results.
    output dspcd_wb_s writeBack,
    output dspcd_br_s branch,
    output dspcd_exc_s exception,
    output logic foreignOp,
    output logic [DATA_W-1:0] ctlWord
);

    typedef enum logic {
        ST_IDLE,
        ST_LOAD
    } dspcd_state_e;

    typedef struct packed {
        dspcd_state_e st;
        logic ready;
        logic [DATA_W-1:0] ctl;
        dspcd_ld_e ldKind;
        dspcd_mem_s mem;
        dspcd_wb_s wb;
        dspcd_br_s br;
        dspcd_exc_s exc;
        logic foreign;
    } dspcd_core_s;

    localparam dspcd_core_s CORE_RESET = '{
        st: ST_IDLE,
        ready: 1'b1,
        ctl: CTL_RESET,
        ldKind: LD_BYTE,
        mem: '0,
        wb: '0,
        br: '0,
        exc: '{valid: 1'b0, code: EXC_NONE},
        foreign: 1'b0
    };

    // Expands the six mask bits into a mask over the control word.
    function automatic logic [DATA_W-1:0] fieldMask(input logic [5:0] m);
        logic [DATA_W-1:0] r;
        r = '0;
        r[POS_HI:POS_LO] = {(POS_HI-POS_LO+1){m[0]}};
        r[SCNT_HI:SCNT_LO] = {(SCNT_HI-SCNT_LO+1){m[1]}};
        r[CARRY_BIT] = m[2];
        r[OUF_HI:OUF_LO] = {(OUF_HI-OUF_LO+1){m[3]}};
        r[CCOND_HI:CCOND_LO] = {(CCOND_HI-CCOND_LO+1){m[4]}};
        r[EFI_BIT] = m[5];
        return r;
    endfunction : fieldMask

    // Maps an instruction word onto the operation class this block executes.
    function automatic dspcd_op_e decodeOp(input logic [DATA_W-1:0] w, output dspcd_ld_e k);
        logic [2:0] row;
        logic [2:0] col;
        dspcd_op_e op;
        // Row and column of the major table.
        row = w[ROW_HI:ROW_LO];
        col = w[COL_HI:COL_LO];
        k = LD_BYTE;
        op = OP_FOREIGN;
        if (row == POOL_ROW && col == POOL_COL) begin
            case (w[MINOR_HI:MINOR_LO])
                MIN_CTL_WRITE: op = OP_CTL_WRITE;
                MIN_CTL_READ: op = OP_CTL_READ;
                MIN_LOAD_BYTE: begin
                    op = OP_LOAD;
                    k = LD_BYTE;
                end
                MIN_LOAD_HALF: begin
                    op = OP_LOAD;
                    k = LD_HALF;
                end
                MIN_LOAD_WORD: begin
                    op = OP_LOAD;
                    k = LD_WORD;
                end
                MIN_POS_BRANCH: op = OP_POS_BRANCH;
                default: op = OP_RESERVED;
            endcase
        end else if (row <= RESV_ROW_MAX && col >= RESV_COL_MIN) begin
            op = OP_RESERVED;
        end else if (row == HIGHER_ROW && col == HIGHER_COL) begin
            op = OP_RESERVED;
        end
        return op;
    endfunction : decodeOp

    logic rstMeta;
    logic rstSyncN;
    dspcd_core_s stateQ;
    dspcd_core_s stateD;
    dspcd_op_e op;
    dspcd_ld_e opKind;
    logic [DATA_W-1:0] ldAddr;
    logic ldMisaligned;
    logic [DATA_W-1:0] ldVal;
    logic [DATA_W-1:0] mask;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    dspcd_load_unit u_load (
        .base(issue.opA),
        .index(issue.opB),
        .kind(stateQ.st == ST_LOAD ? stateQ.ldKind : opKind),
        .memData(memRespData),
        .addr(ldAddr),
        .misaligned(ldMisaligned),
        .loadVal(ldVal)
    );

    // Decodes the offered word apart from the state update, so no process reads its own output.
    always_comb begin
        op = decodeOp(issue.insn, opKind);
        mask = fieldMask(issue.insn[MASK_HI:MASK_LO]);
    end

    always_comb begin
        stateD = stateQ;
        stateD.mem.valid = 1'b0;
        stateD.wb.valid = 1'b0;
        stateD.br = '0;
        stateD.exc = '{valid: 1'b0, code: EXC_NONE};
        stateD.foreign = 1'b0;
        case (stateQ.st)
            ST_IDLE: begin
                if (issue.valid) begin
                    case (op)
                        OP_CTL_WRITE: begin
                            stateD.ctl = (stateQ.ctl & ~mask) | (issue.opA & mask);
                        end
                        OP_CTL_READ: begin
                            stateD.wb.valid = 1'b1;
                            stateD.wb.regNum = issue.insn[TGT_HI:TGT_LO];
                            stateD.wb.data = (issue.opA & ~mask) | (stateQ.ctl & mask);
                        end
                        OP_LOAD: begin
                            if (ldMisaligned) begin
                                stateD.exc = '{valid: 1'b1, code: EXC_ADDR};
                            end else begin
                                stateD.mem = '{valid: 1'b1, addr: ldAddr, size: opKind};
                                stateD.ldKind = opKind;
                                stateD.wb.regNum = issue.insn[DEST_HI:DEST_LO];
                                stateD.st = ST_LOAD;
                                stateD.ready = 1'b0;
                            end
                        end
                        OP_POS_BRANCH: begin
                            stateD.br.valid = 1'b1;
                            stateD.br.taken = stateQ.ctl[POS_HI:POS_LO] >= POS_LIMIT;
                        end
                        OP_RESERVED: begin
                            stateD.exc = '{valid: 1'b1, code: EXC_RESERVED};
                        end
                        default: begin
                            stateD.foreign = 1'b1;
                        end
                    endcase
                end
            end
            ST_LOAD: begin
                if (memRespValid) begin
                    stateD.wb.valid = 1'b1;
                    stateD.wb.data = ldVal;
                    stateD.st = ST_IDLE;
                    stateD.ready = 1'b1;
                end
            end
            default: begin
                stateD = CORE_RESET;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            stateQ <= CORE_RESET;
        end else begin
            stateQ <= stateD;
        end
    end

    assign issueReady = stateQ.ready;
    assign memReq = stateQ.mem;
    assign writeBack = stateQ.wb;
    assign branch = stateQ.br;
    assign exception = stateQ.exc;
    assign foreignOp = stateQ.foreign;
    assign ctlWord = stateQ.ctl;

endmodule : dspcd_core

// >>> shared/dspcd_pkg.sv
// Package with constants, fields and carriers of the signal-processing decode block.
package dspcd_pkg;

    localparam int DATA_W = 32;

    // Major opcode row and column fields.
    localparam int ROW_HI = 31;
    localparam int ROW_LO = 29;
    localparam int COL_HI = 28;
    localparam int COL_LO = 26;
    localparam logic [2:0] POOL_ROW = 3'h0;
    localparam logic [2:0] POOL_COL = 3'h0;
    localparam logic [2:0] HIGHER_ROW = 3'h6;
    localparam logic [2:0] HIGHER_COL = 3'h2;
    localparam logic [2:0] RESV_ROW_MAX = 3'h1;
    localparam logic [2:0] RESV_COL_MIN = 3'h4;

    // Minor field of the pool and its operation codes.
    localparam int MINOR_HI = 5;
    localparam int MINOR_LO = 0;
    localparam logic [5:0] MIN_CTL_WRITE = 6'h01;
    localparam logic [5:0] MIN_CTL_READ = 6'h02;
    localparam logic [5:0] MIN_LOAD_BYTE = 6'h03;
    localparam logic [5:0] MIN_LOAD_HALF = 6'h04;
    localparam logic [5:0] MIN_LOAD_WORD = 6'h05;
    localparam logic [5:0] MIN_POS_BRANCH = 6'h06;

    // Register number fields and the mask field.
    localparam int TGT_HI = 25;
    localparam int TGT_LO = 21;
    localparam int DEST_HI = 15;
    localparam int DEST_LO = 11;
    localparam int MASK_HI = 19;
    localparam int MASK_LO = 14;

    // Control word field layout, one field per mask bit.
    localparam int POS_HI = 5;
    localparam int POS_LO = 0;
    localparam int SCNT_HI = 12;
    localparam int SCNT_LO = 7;
    localparam int CARRY_BIT = 13;
    localparam int EFI_BIT = 14;
    localparam int OUF_HI = 23;
    localparam int OUF_LO = 16;
    localparam int CCOND_HI = 31;
    localparam int CCOND_LO = 24;
    localparam logic [DATA_W-1:0] CTL_RESET = 32'h0000_0000;
    localparam logic [5:0] POS_LIMIT = 6'h20;

    typedef enum logic [2:0] {
        OP_FOREIGN,
        OP_CTL_WRITE,
        OP_CTL_READ,
        OP_LOAD,
        OP_POS_BRANCH,
        OP_RESERVED
    } dspcd_op_e;

    typedef enum logic [1:0] {
        LD_BYTE,
        LD_HALF,
        LD_WORD
    } dspcd_ld_e;

    typedef enum logic [1:0] {
        EXC_NONE,
        EXC_RESERVED,
        EXC_ADDR
    } dspcd_exc_e;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] insn;
        logic [DATA_W-1:0] opA;
        logic [DATA_W-1:0] opB;
    } dspcd_issue_s;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] addr;
        dspcd_ld_e size;
    } dspcd_mem_s;

    typedef struct packed {
        logic valid;
        logic [4:0] regNum;
        logic [DATA_W-1:0] data;
    } dspcd_wb_s;

    typedef struct packed {
        logic valid;
        logic taken;
    } dspcd_br_s;

    typedef struct packed {
        logic valid;
        dspcd_exc_e code;
    } dspcd_exc_s;

endpackage : dspcd_pkg

// >>> rtl/dspcd_load_unit.sv
// Indexed load address adder, alignment check and load data extension.
`timescale 1ns/1ps
module dspcd_load_unit
    import dspcd_pkg::*;
(
    // Address operands.
    input wire logic [DATA_W-1:0] base,
    input wire logic [DATA_W-1:0] index,
    input wire dspcd_ld_e kind,
    // Returned memory word.
    input wire logic [DATA_W-1:0] memData,
    // Results.
    output logic [DATA_W-1:0] addr,
    output logic misaligned,
    output logic [DATA_W-1:0] loadVal
);

    always_comb begin
        addr = base + index;
        misaligned = 1'b0;
        loadVal = memData;
        case (kind)
            LD_BYTE: begin
                loadVal = {24'h00_0000, memData[7:0]};
            end
            LD_HALF: begin
                misaligned = addr[0];
                loadVal = {{16{memData[15]}}, memData[15:0]};
            end
            LD_WORD: begin
                misaligned = addr[1:0] != 2'h0;
                loadVal = memData;
            end
            default: begin
                loadVal = memData;
            end
        endcase
    end

endmodule : dspcd_load_unit

// >>> sim/dspcd_core_checker.sv
// Assertions on the ports of the decode and execution block.
`timescale 1ns/1ps
module dspcd_core_checker
    import dspcd_pkg::*;
(
    // Clock, reset and issue.
    input wire logic ref_clk,
    input wire logic resetn,
    input wire dspcd_issue_s issue,
    input wire logic issueReady,
    // Memory.
    input wire dspcd_mem_s memReq,
    input wire logic memRespValid,
    input wire logic [DATA_W-1:0] memRespData,
    // Results.
    input wire dspcd_wb_s writeBack,
    input wire dspcd_br_s branch,
    input wire dspcd_exc_s exception,
    input wire logic foreignOp,
    input wire logic [DATA_W-1:0] ctlWord
);
    logic take;
    logic pool;
    logic [5:0] mnr;
    logic [5:0] m;
    logic [31:0] fm;
    assign take = issue.valid && issueReady;
    assign pool = issue.insn[31:26] == 6'h00;
    assign mnr = issue.insn[5:0];
    assign m = issue.insn[19:14];
    assign fm = {{8{m[4]}}, {8{m[3]}}, 1'b0, m[5], m[2], {6{m[1]}}, 1'b0, {6{m[0]}}};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    chk_ctl_write_sel: assert property (
        take && pool && mnr == MIN_CTL_WRITE |=>
        (ctlWord & $past(fm)) == ($past(issue.opA) & $past(fm)))
        else $error("selected control field not written");
    chk_ctl_write_keep: assert property (
        take && pool && mnr == MIN_CTL_WRITE |=>
        (ctlWord & ~$past(fm)) == ($past(ctlWord) & ~$past(fm)))
        else $error("unselected control field changed");
    chk_ctl_read_merge: assert property (
        take && pool && mnr == MIN_CTL_READ |=> writeBack.valid &&
        writeBack.regNum == $past(issue.insn[25:21]) && writeBack.data ==
        (($past(issue.opA) & ~$past(fm)) | ($past(ctlWord) & $past(fm))))
        else $error("control read result wrong");
    chk_branch_pos: assert property (
        take && pool && mnr == MIN_POS_BRANCH |=> branch.valid &&
        branch.taken == (($past(ctlWord) & 32'h3F) >= 32'h20))
        else $error("position branch decision wrong");
    chk_load_addr: assert property (
        take && pool && mnr == MIN_LOAD_BYTE |=> memReq.valid && memReq.size == LD_BYTE &&
        memReq.addr == $past(issue.opA) + $past(issue.opB))
        else $error("byte load request wrong");
    chk_resv_slot: assert property (
        take && issue.insn[31:29] <= RESV_ROW_MAX && issue.insn[28:26] >= RESV_COL_MIN |=>
        exception.valid && exception.code == EXC_RESERVED && !memReq.valid && $stable(ctlWord))
        else $error("reserved slot not refused");
    chk_higher_slot: assert property (
        take && issue.insn[31:26] == {HIGHER_ROW, HIGHER_COL} |=>
        exception.valid && exception.code == EXC_RESERVED && !foreignOp)
        else $error("higher level slot not refused");
    chk_minor_unknown: assert property (
        take && pool && (mnr == 6'h00 || mnr > MIN_POS_BRANCH) |=>
        exception.valid && exception.code == EXC_RESERVED && !writeBack.valid)
        else $error("unknown minor code not refused");
endmodule : dspcd_core_checker

// >>> sim/dspcd_mem_model.sv
// Data memory stand-in that answers load requests after a set delay.
`timescale 1ns/1ps
module dspcd_mem_model
    import dspcd_pkg::*;
#(
    parameter logic [31:0] KEY = 32'h8C3F_F0A7
)
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic resetn,
    // Request and answer delay.
    input wire dspcd_mem_s memReq,
    input wire logic [3:0] lat,
    // Answer.
    output logic memRespValid,
    output logic [31:0] memRespData
);
    logic busy;
    logic [3:0] cnt;
    logic [31:0] adr;
    // Between answers the data line shows the inverse of its last value.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            memRespValid <= 1'b0;
            memRespData <= 32'h0;
            busy <= 1'b0;
        end else begin
            memRespValid <= 1'b0;
            memRespData <= ~memRespData;
            if (memReq.valid) begin
                busy <= 1'b1;
                cnt <= lat;
                adr <= memReq.addr;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                memRespValid <= 1'b1;
                memRespData <= adr ^ KEY;
            end
        end
    end
endmodule : dspcd_mem_model

// >>> sim/tb_dspcd_core.sv
// Self-checking bench for the decode and execution block.
`timescale 1ns/1ps
module tb_dspcd_core;
    import dspcd_pkg::*;
    localparam logic [31:0] KEY = 32'h8C3F_F0A7;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    dspcd_issue_s issue = '0;
    logic [3:0] lat = 4'h0;
    logic issueReady, memRespValid, foreignOp;
    logic [31:0] memRespData, ctlWord;
    dspcd_mem_s memReq;
    dspcd_wb_s writeBack;
    dspcd_br_s branch;
    dspcd_exc_s exception;
    int n_mismatch = 0;
    int n_checks = 0;
    always #10 ref_clk = ~ref_clk;
    dspcd_core i_dspcd_core (.ref_clk(ref_clk), .resetn(resetn), .issue(issue),
        .issueReady(issueReady), .memReq(memReq), .memRespValid(memRespValid),
        .memRespData(memRespData), .writeBack(writeBack), .branch(branch),
        .exception(exception), .foreignOp(foreignOp), .ctlWord(ctlWord));
    dspcd_mem_model #(.KEY(KEY)) i_dspcd_mem_model (.ref_clk(ref_clk), .resetn(resetn),
        .memReq(memReq), .lat(lat), .memRespValid(memRespValid), .memRespData(memRespData));
    task automatic check(input logic [37:0] seen, input logic [37:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [31:0] mk(input logic [5:0] mn, input logic [5:0] msk,
        input logic [4:0] tgt, input logic [4:0] dst);
        mk = {6'h00, tgt, 1'b0, msk, 8'h00, mn} | {16'h0, dst, 11'h0};
    endfunction : mk
    task automatic go(input logic [31:0] insn, input logic [31:0] a, input logic [31:0] b);
        @(negedge ref_clk);
        issue = '{1'b1, insn, a, b};
        @(negedge ref_clk);
        issue.valid = 1'b0;
    endtask : go
    task automatic t_ctl;
        go(mk(MIN_CTL_WRITE, 6'h3F, 5'h00, 5'h00), 32'hFFFF_FFFF, 32'h0);
        check({6'h0, ctlWord}, {6'h0, 32'hFFFF_7FBF});
        go(mk(MIN_CTL_WRITE, 6'h01, 5'h00, 5'h00), 32'h0, 32'h0);
        check({6'h0, ctlWord}, {6'h0, 32'hFFFF_7F80});
        go(mk(MIN_CTL_READ, 6'h08, 5'h09, 5'h00), 32'h1234_5678, 32'h0);
        check({writeBack.valid, writeBack.regNum, writeBack.data}, {6'h29, 32'h12FF_5678});
        $display("control access test done");
    endtask : t_ctl
    task automatic t_branch;
        logic [5:0] pv [4] = '{6'h1F, 6'h20, 6'h3F, 6'h00};
        foreach (pv[i]) begin
            go(mk(MIN_CTL_WRITE, 6'h01, 5'h00, 5'h00), {26'h0, pv[i]}, 32'h0);
            go(mk(MIN_POS_BRANCH, 6'h00, 5'h00, 5'h00), 32'h0, 32'h0);
            check({36'h0, branch.valid, branch.taken}, {36'h0, 1'b1, pv[i] >= 6'h20});
        end
        $display("position branch test done");
    endtask : t_branch
    task automatic ld(input logic [5:0] mn, input logic [31:0] a, input logic [31:0] b,
        input logic [3:0] l);
        logic [31:0] d;
        dspcd_ld_e sz;
        d = (a + b) ^ KEY;
        sz = mn == MIN_LOAD_BYTE ? LD_BYTE : (mn == MIN_LOAD_HALF ? LD_HALF : LD_WORD);
        lat = l;
        go(mk(mn, 6'h00, 5'h00, 5'h07), a, b);
        check({2'h0, memReq.valid, issueReady, memReq.size, memReq.addr},
            {2'h0, 1'b1, 1'b0, sz, a + b});
        for (int k = 0; k < 20 && writeBack.valid !== 1'b1; k++) @(negedge ref_clk);
        if (mn == MIN_LOAD_BYTE) d = {24'h0, d[7:0]};
        if (mn == MIN_LOAD_HALF) d = {{16{d[15]}}, d[15:0]};
        check({writeBack.valid, writeBack.regNum, writeBack.data}, {6'h27, d});
    endtask : ld
    task automatic t_load;
        ld(MIN_LOAD_BYTE, 32'h0000_1000, 32'h0000_0003, 4'h0);
        ld(MIN_LOAD_HALF, 32'hFFFF_FFF0, 32'h0000_0014, 4'h3);
        ld(MIN_LOAD_WORD, 32'h0000_0100, 32'h0000_0008, 4'h5);
        ld(MIN_LOAD_BYTE, 32'hFFFF_FFFF, 32'h0000_0002, 4'h1);
        go(mk(MIN_LOAD_HALF, 6'h00, 5'h00, 5'h07), 32'h1, 32'h0);
        check({34'h0, memReq.valid, exception.valid, exception.code}, {36'h1, EXC_ADDR});
        $display("indexed load test done");
    endtask : t_load
    task automatic t_decode;
        logic resv;
        logic [5:0] mv [3] = '{6'h00, 6'h07, 6'h3F};
        for (int i = 1; i < 64; i++) begin
            resv = (i[5:3] <= 1 && i[2:0] >= 4) || (i[5:3] == 6 && i[2:0] == 2);
            go({i[5:0], 26'h0}, 32'h0, 32'h0);
            check({35'h0, foreignOp, exception.valid, memReq.valid}, {35'h0, !resv, resv, 1'b0});
            if (resv) check({36'h0, exception.code}, {36'h0, EXC_RESERVED});
        end
        foreach (mv[i]) begin
            go(mk(mv[i], 6'h00, 5'h00, 5'h00), 32'h0, 32'h0);
            check({35'h0, exception.valid, writeBack.valid, memReq.valid}, 38'h4);
        end
        check({6'h0, ctlWord}, {6'h0, 32'hFFFF_7F80});
        $display("decode test done");
    endtask : t_decode
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        check({5'h0, issueReady, ctlWord}, {5'h0, 1'b1, 32'h0});
        t_ctl();
        t_branch();
        t_load();
        t_decode();
        tally_and_finish();
    end
endmodule : tb_dspcd_core
bind dspcd_core dspcd_core_checker i_dspcd_core_checker (.ref_clk(ref_clk), .resetn(resetn),
    .issue(issue), .issueReady(issueReady), .memReq(memReq), .memRespValid(memRespValid),
    .memRespData(memRespData), .writeBack(writeBack), .branch(branch),
    .exception(exception), .foreignOp(foreignOp), .ctlWord(ctlWord));
